//--- logic/sif_map.vh
`ifndef SIF_MAP_VH
`define SIF_MAP_VH
// ==========================================================
// Register byte addresses (index times four)
`define SIF_IDX_PRIO        16'hff20
`define SIF_IDX_ENAB        16'hff23
`define SIF_IDX_FLAG        16'hff25
`define SIF_IDX_CTRL        16'hff49
`define SIF_IDX_MODE        16'hff48
`define SIF_IDX_DATA        16'hff4a
`define SIF_ADDR_W          18
`define SIF_ADDR_PRIO       18'h3fc80
`define SIF_ADDR_ENAB       18'h3fc8c
`define SIF_ADDR_FLAG       18'h3fc94
`define SIF_ADDR_CTRL       18'h3fd24
`define SIF_ADDR_MODE       18'h3fd20
`define SIF_ADDR_DATA       18'h3fd28
// ==========================================================
// Field positions
`define SIF_PRIO_LO         4
`define SIF_PRIO_HI         5
`define SIF_EV_TX           0
`define SIF_EV_RX           1
`define SIF_EV_ERR          2
`define SIF_CTL_TRANSMIT_ENABLE_BIT        0
`define SIF_CTL_TRANSMIT_TRIGGER       1
`define SIF_CTL_RECEIVE_ENABLE_BIT        2
`define SIF_CTL_RECEIVE_TRIGGER       3
`define SIF_CTL_OVR         4
`define SIF_CTL_PAR         5
`define SIF_CTL_FRM         6
`define SIF_MODE_ASYNC      2
`define SIF_MODE_PODD       5
`define SIF_MODE_PEN        6
// ==========================================================
// Reset values and response codes
`define SIF_RST_BYTE        8'h00
`define SIF_RESP_OKAY       2'b00
`define SIF_RESP_SLVERR     2'b10
`endif

//--- logic/sif_rx_flags.v
// Overview of operation
// RULE1: Async frame before receive trigger sets overrun
// RULE2: Async parity mismatch sets parity error flag
// RULE3: Async low stop bit sets framing error
// RULE4: Error flags clear on write one only; code also clears them while receive is disabled
// RULE5: Error flags zero at reset, receive disabled
// RULE6: Line high loads one into receive buffer
// RULE7: Receive buffer is not reset
// RULE8: Two-bit priority field selects level, resets zero
// RULE9: Enables at bits 0..2 gate three interrupts
// RULE10: Transmit done sets transmit event flag
// RULE11: Buffer load sets receive event flag
// RULE12: Any receive error sets error event flag
// RULE13: Event flags set regardless of enable, priority
// RULE14: Request when flag, enable, level above mask
// RULE15: Event flags clear on write one, reset zero
// RULE16: Error flag leads receive flag half bit
// RULE17: Timer clock: error leads by one underflow
// RULE18: Overrun leaves receive event flag unset
// RULE19: Mode changes only with both enables off
// RULE20: No retrigger while direction is busy; code holds off only the transmit trigger, with i_tx_idle
// RULE21: Clear enables before sleep, not mid-transfer
// RULE22: Synchronous mode is half duplex only
// RULE23: Read word, then write receive trigger
// RULE24: Parity enabled: top received bit is parity
// RULE25: Set wins over same-cycle clear
//
// The AXI4-Lite slave port was decided locally.
`include "sif_map.vh"
`default_nettype none
module sif_rx_flags (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_reset,
    // AXI4-Lite write address
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [17:0] i_awaddr,
    // AXI4-Lite write data
    input  wire        i_wvalid,
    output reg         o_wready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    // AXI4-Lite write response
    output reg         o_bvalid,
    input  wire        i_bready,
    output reg  [1:0]  o_bresp,
    // AXI4-Lite read
    input  wire        i_arvalid,
    output reg         o_arready,
    input  wire [17:0] i_araddr,
    output reg         o_rvalid,
    input  wire        i_rready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    // Receive and transmit datapath events
    input  wire [7:0]  i_rx_word,
    input  wire        i_rx_stop_bit,
    input  wire        i_rx_done,
    input  wire        i_rx_err_early,
    input  wire        i_tx_done,
    input  wire        i_tx_idle,
    input  wire        i_rx_idle,
    // CPU interrupt interface
    input  wire [1:0]  i_cpu_mask_level,
    output reg  [1:0]  o_irq_level,
    output reg         o_irq_req,
    // Control to the datapath
    output reg         o_transmit_enable_bit,
    output reg         o_receive_enable_bit,
    output reg         o_transmit_trigger,
    output reg         o_receive_trigger,
    output reg         o_async_mode,
    output reg         o_parity_enable_bit,
    output reg         o_parity_odd
);
    // ==========================================================
    // State
    reg [7:0]  prio_ff;
    reg [2:0]  enab_ff;
    reg [2:0]  event_ff;
    reg        ovr_ff;
    reg        par_ff;
    reg        frm_ff;
    reg        buf_full_ff;
    reg        err_seen_ff;
    reg [7:0]  mode_ff;
    reg [7:0]  rx_buf_ff;
    reg [17:0] aw_ff;
    reg [31:0] wd_ff;
    reg [3:0]  ws_ff;
    reg        aw_have_ff;
    reg        w_have_ff;

    wire async_on = mode_ff[`SIF_MODE_ASYNC];
    wire pen_on   = mode_ff[`SIF_MODE_PEN] & async_on;

    // Single bus write strobe once both halves arrive
    wire       wr_go  = aw_have_ff & w_have_ff & ~o_bvalid;
    wire       wr_ok  = wr_go & ws_ff[0];
    wire       b_done = o_bvalid & i_bready;
    wire [7:0] wb     = wd_ff[7:0];

    function hit;
        input [17:0] a;
        input [17:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    // Any address outside the map answers with an error response
    function mapped;
        input [17:0] a;
        begin
            mapped = hit(a, `SIF_ADDR_PRIO) | hit(a, `SIF_ADDR_ENAB)
                     | hit(a, `SIF_ADDR_FLAG) | hit(a, `SIF_ADDR_CTRL)
                     | hit(a, `SIF_ADDR_MODE) | hit(a, `SIF_ADDR_DATA);
        end
    endfunction

    wire wr_prio = wr_ok & hit(aw_ff, `SIF_ADDR_PRIO);
    wire wr_enab = wr_ok & hit(aw_ff, `SIF_ADDR_ENAB);
    wire wr_flag = wr_ok & hit(aw_ff, `SIF_ADDR_FLAG);
    wire wr_ctrl = wr_ok & hit(aw_ff, `SIF_ADDR_CTRL);
    wire wr_mode = wr_ok & hit(aw_ff, `SIF_ADDR_MODE);

    // ==========================================================
    // Error detection; parity counts the whole word, top bit is parity
    wire rx_en      = o_receive_enable_bit;
    wire par_bad    = pen_on & ((^i_rx_word) != mode_ff[`SIF_MODE_PODD]); // see RULE2 RULE24
    wire frm_bad    = async_on & ~i_rx_stop_bit;                        // see RULE3
    wire ovr_bad    = async_on & buf_full_ff;                           // see RULE1
    wire pf_err     = i_rx_err_early & rx_en & (par_bad | frm_bad);     // see RULE16 RULE17
    wire ovr_ev     = i_rx_done & rx_en & ovr_bad;
    wire load_ev    = i_rx_done & rx_en & ~ovr_bad;                     // see RULE18
    wire pf_late    = i_rx_done & rx_en & (par_bad | frm_bad) & ~err_seen_ff;
    wire rx_trig_w  = wr_ctrl & wb[`SIF_CTL_RECEIVE_TRIGGER];

    // Write-one clears and the two late or early error sets
    wire ovr_clr    = wr_ctrl & wb[`SIF_CTL_OVR];
    wire par_clr    = wr_ctrl & wb[`SIF_CTL_PAR];
    wire frm_clr    = wr_ctrl & wb[`SIF_CTL_FRM];
    wire par_set    = (pf_err | pf_late) & par_bad;
    wire frm_set    = (pf_err | pf_late) & frm_bad;

    // ==========================================================
    // Error flags
    always @(posedge i_clk) begin
        if (i_reset || !rx_en) begin
            ovr_ff <= 1'b0; // see RULE5
            par_ff <= 1'b0;
            frm_ff <= 1'b0;
            err_seen_ff <= 1'b0;
        end else begin
            // Set wins over a same-cycle write of one
            ovr_ff <= ovr_ev | (ovr_ff & ~ovr_clr);   // see RULE4 RULE25
            par_ff <= par_set | (par_ff & ~par_clr);
            frm_ff <= frm_set | (frm_ff & ~frm_clr);
            if (i_rx_done)
                err_seen_ff <= 1'b0;
            else if (pf_err)
                err_seen_ff <= 1'b1;
        end
    end

    // ==========================================================
    // Receive buffer, full marker and triggers
    always @(posedge i_clk) begin
        if (load_ev)
            rx_buf_ff <= i_rx_word; // see RULE6 RULE7
    end

    always @(posedge i_clk) begin
        if (i_reset || !rx_en) begin
            buf_full_ff <= 1'b0;
        end else if (load_ev) begin
            buf_full_ff <= 1'b1;
        end else if (rx_trig_w) begin
            buf_full_ff <= 1'b0; // see RULE23
        end
    end

    // ==========================================================
    // Enable bits
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_transmit_enable_bit <= 1'b0;
            o_receive_enable_bit  <= 1'b0;
        end else if (wr_ctrl) begin
            o_transmit_enable_bit <= wb[`SIF_CTL_TRANSMIT_ENABLE_BIT];
            o_receive_enable_bit  <= wb[`SIF_CTL_RECEIVE_ENABLE_BIT];
        end
    end

    // Trigger pulses last one cycle; busy status comes from the datapath
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_transmit_trigger <= 1'b0;
            o_receive_trigger  <= 1'b0;
        end else begin
            o_transmit_trigger <= wr_ctrl & wb[`SIF_CTL_TRANSMIT_TRIGGER] & i_tx_idle; // see RULE20
            o_receive_trigger  <= rx_trig_w;
        end
    end

    // Mode accepted only while both directions disabled, so a frame
    // never sees its format change half way
    always @(posedge i_clk) begin
        if (i_reset) begin
            mode_ff <= `SIF_RST_BYTE;
        end else if (wr_mode && !o_transmit_enable_bit && !o_receive_enable_bit) begin
            mode_ff <= wb; // see RULE19
        end
    end

    // ==========================================================
    // Event flags, enables, priority
    wire [2:0] ev_set = {pf_err | ovr_ev | pf_late,
                         load_ev,
                         i_tx_done};                  // see RULE10 RULE11 RULE12 RULE13
    wire [2:0] ev_clr = wr_flag ? wb[2:0] : 3'b000;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ev
            always @(posedge i_clk) begin
                if (i_reset)
                    event_ff[g] <= 1'b0;
                else
                    event_ff[g] <= ev_set[g] | (event_ff[g] & ~ev_clr[g]); // see RULE15 RULE25
            end
        end
    endgenerate

    always @(posedge i_clk) begin
        if (i_reset) begin
            prio_ff <= `SIF_RST_BYTE; // see RULE8
            enab_ff <= 3'b000;        // see RULE9
        end else begin
            if (wr_prio)
                prio_ff <= wb;
            if (wr_enab)
                enab_ff <= wb[2:0];
        end
    end

    wire [1:0] lvl = prio_ff[`SIF_PRIO_HI:`SIF_PRIO_LO];

    always @(posedge i_clk) begin
        if (i_reset) begin
            o_irq_req   <= 1'b0;
            o_irq_level <= 2'b00;
        end else begin
            // Level zero never exceeds a mask, so it never requests
            o_irq_req   <= (|(event_ff & enab_ff)) && (lvl > i_cpu_mask_level); // see RULE14
            o_irq_level <= lvl;
        end
    end

    // ==========================================================
    // Mode levels to the datapath, one cycle behind the register
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_async_mode        <= 1'b0;
            o_parity_enable_bit <= 1'b0;
            o_parity_odd        <= 1'b0;
        end else begin
            o_async_mode        <= async_on;
            o_parity_enable_bit <= pen_on;
            o_parity_odd        <= mode_ff[`SIF_MODE_PODD];
        end
    end

    // ==========================================================
    // AXI4-Lite write address
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_awready  <= 1'b1;
            aw_have_ff <= 1'b0;
            aw_ff      <= 18'h00000;
        end else if (i_awvalid && o_awready) begin
            aw_ff      <= i_awaddr;
            aw_have_ff <= 1'b1;
            o_awready  <= 1'b0;
        end else if (b_done) begin
            // Reopen only after the response: one write at a time
            aw_have_ff <= 1'b0;
            o_awready  <= 1'b1;
        end
    end

    // ==========================================================
    // AXI4-Lite write data
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_wready  <= 1'b1;
            w_have_ff <= 1'b0;
            wd_ff     <= 32'h00000000;
            ws_ff     <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            wd_ff     <= i_wdata;
            ws_ff     <= i_wstrb;
            w_have_ff <= 1'b1;
            o_wready  <= 1'b0;
        end else if (b_done) begin
            w_have_ff <= 1'b0;
            o_wready  <= 1'b1;
        end
    end

    // ==========================================================
    // AXI4-Lite write response
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_bvalid <= 1'b0;
            o_bresp  <= `SIF_RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= mapped(aw_ff) ? `SIF_RESP_OKAY : `SIF_RESP_SLVERR;
        end else if (b_done) begin
            o_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    reg [31:0] rd_val;
    reg        rd_hit;
    always @* begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case (i_araddr)
            `SIF_ADDR_PRIO: rd_val[7:0] = prio_ff;
            `SIF_ADDR_ENAB: rd_val[2:0] = enab_ff;
            `SIF_ADDR_FLAG: rd_val[2:0] = event_ff;
            `SIF_ADDR_CTRL: rd_val[6:0] = {frm_ff, par_ff, ovr_ff, ~i_rx_idle,
                                           o_receive_enable_bit, ~i_tx_idle,
                                           o_transmit_enable_bit};
            `SIF_ADDR_MODE: rd_val[7:0] = mode_ff;
            `SIF_ADDR_DATA: rd_val[7:0] = rx_buf_ff;
            default:        rd_hit = 1'b0;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `SIF_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_val;
            o_rresp   <= rd_hit ? `SIF_RESP_OKAY : `SIF_RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- test/sif_far_end.sv
`default_nettype none
// ======
// Remote serial end
module sif_far_end (
    input  wire logic       i_clk,
    output var  logic [7:0] o_rx_word = 8'h5a,
    output var  logic       o_stop = 1'b0,
    output var  logic       o_done = 1'b0,
    output var  logic       o_early = 1'b0,
    output var  logic       o_tx_done = 1'b0,
    output var  logic       o_tx_idle = 1'b1,
    output var  logic       o_rx_idle = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic frame(input logic [7:0] w, input logic s, input logic e);
        o_rx_idle <= 1'b0;
        o_rx_word <= w;
        o_stop <= s;
        repeat (4) @(posedge i_clk);
        o_early <= e;
        @(posedge i_clk);
        o_early <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_done <= 1'b1;
        @(posedge i_clk);
        o_done <= 1'b0;
        o_rx_idle <= 1'b1;
        // Lines no longer valid: never leave the old word showing
        o_rx_word <= ~w;
        o_stop <= ~s;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic tx_end;
        o_tx_idle <= 1'b0;
        repeat (3) @(posedge i_clk);
        o_tx_done <= 1'b1;
        @(posedge i_clk);
        o_tx_done <= 1'b0;
        o_tx_idle <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

//--- test/sif_rx_flags_props.sv
`include "sif_map.vh"
`default_nettype none
// ======
// Bus, request and trigger pulse checks
module sif_rx_flags_props (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       o_awready,
    input wire logic       o_wready,
    input wire logic       o_bvalid,
    input wire logic       i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic       i_arvalid,
    input wire logic       o_arready,
    input wire logic       o_rvalid,
    input wire logic       i_rready,
    input wire logic [1:0] i_cpu_mask_level,
    input wire logic [1:0] o_irq_level,
    input wire logic       o_irq_req,
    input wire logic       o_transmit_trigger
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    property p_bhold; o_bvalid && !i_bready |=> o_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_bref; o_bvalid |-> !o_awready && !o_wready; endproperty
    a_bref: assert property (p_bref) else $error("write taken during response");
    property p_bresp; o_bvalid |-> o_bresp == `SIF_RESP_OKAY || o_bresp == `SIF_RESP_SLVERR;
    endproperty
    a_bresp: assert property (p_bresp) else $error("bad bresp");
    property p_rans; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read not answered");
    property p_rhold; o_rvalid && !i_rready |=> o_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    property p_rref; o_rvalid |-> !o_arready; endproperty
    a_rref: assert property (p_rref) else $error("read taken during answer");
    // Request is registered, so it follows last cycle's level and mask
    property p_irq; o_irq_req |-> o_irq_level > $past(i_cpu_mask_level); endproperty
    a_irq: assert property (p_irq) else $error("request at or below mask");
    property p_trig; o_transmit_trigger |=> !o_transmit_trigger; endproperty
    a_trig: assert property (p_trig) else $error("trigger not a pulse");
endmodule
bind sif_rx_flags sif_rx_flags_props u_props (.i_clk, .i_reset, .o_awready, .o_wready,
    .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid, .i_rready,
    .i_cpu_mask_level, .o_irq_level, .o_irq_req, .o_transmit_trigger);
`default_nettype wire

//--- test/sif_rx_flags_tb_top.sv
`include "sif_map.vh"
`default_nettype none
// ======
// Bench top
module sif_rx_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic        awr, wrd, bv, arr, rv, req, stp, dn, erl, txd, txi, rxi;
    logic [17:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0]  bresp, rresp, lvl, mask = 0;
    logic [7:0]  rxw;
    logic        transmit_enable_bit, receive_enable_bit, txtg, rxtg, asy, pen, podd;
    int          fail_count, checks_done, cyc, tx_trig_n, rx_trig_n;
    sif_rx_flags dut (.i_clk(clk), .i_reset(rst), .i_awvalid(awv), .o_awready(awr),
        .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'h1),
        .o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
        .i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rdat), .o_rresp(rresp),
        .i_rx_word(rxw), .i_rx_stop_bit(stp), .i_rx_done(dn), .i_rx_err_early(erl),
        .i_tx_done(txd), .i_tx_idle(txi), .i_rx_idle(rxi), .i_cpu_mask_level(mask),
        .o_irq_level(lvl), .o_irq_req(req), .o_transmit_enable_bit(transmit_enable_bit),
        .o_receive_enable_bit(receive_enable_bit), .o_transmit_trigger(txtg), .o_receive_trigger(rxtg),
        .o_async_mode(asy), .o_parity_enable_bit(pen), .o_parity_odd(podd));
    sif_far_end far (.i_clk(clk), .o_rx_word(rxw), .o_stop(stp), .o_done(dn),
        .o_early(erl), .o_tx_done(txd), .o_tx_idle(txi), .o_rx_idle(rxi));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (txtg) tx_trig_n++;
        if (rxtg) rx_trig_n++;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize;
        $display("Checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        bit ad, dd;
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awr) ad = 1;
            if (wrd) dd = 1;
            awv <= !ad;
            wv <= !dd;
        end
        do @(posedge clk); while (bv !== 1'b1);
        br <= 1'b0;
        chk(bresp, `SIF_RESP_OKAY);
        @(posedge clk);
    endtask
    task automatic rd(input logic [17:0] a, input logic [7:0] m, input logic [7:0] e,
                      input logic [1:0] r = `SIF_RESP_OKAY);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rr <= 1'b0;
        chk(rdat & {24'h0, m}, {24'h0, e & m});
        chk(rresp, r);
        @(posedge clk);
    endtask
    task automatic t_reset;
        rd(`SIF_ADDR_PRIO, 8'h30, 8'h00);
        rd(`SIF_ADDR_ENAB, 8'h07, 8'h00);
        rd(`SIF_ADDR_FLAG, 8'h07, 8'h00);
        rd(`SIF_ADDR_CTRL, 8'h70, 8'h00);
        rd(18'h0, 8'hff, 8'h00, `SIF_RESP_SLVERR);
    endtask
    task automatic t_tx;
        far.tx_end();
        rd(`SIF_ADDR_FLAG, 8'h07, 8'h01);
        wr(`SIF_ADDR_FLAG, 8'h00);
        rd(`SIF_ADDR_FLAG, 8'h07, 8'h01);
        wr(`SIF_ADDR_CTRL, 8'h03);
        chk(transmit_enable_bit, 1'b1);
        chk(tx_trig_n, 1);
        wr(`SIF_ADDR_CTRL, 8'h00);
        chk(transmit_enable_bit, 1'b0);
    endtask
    task automatic t_rx;
        wr(`SIF_ADDR_MODE, 8'h44);
        chk({asy, pen, podd}, 3'b110);
        wr(`SIF_ADDR_CTRL, 8'h0c);
        chk(receive_enable_bit, 1'b1);
        far.frame(8'ha5, 1'b1, 1'b0);
        rd(`SIF_ADDR_FLAG, 8'h07, 8'h03);
        rd(`SIF_ADDR_DATA, 8'hff, 8'ha5);
        wr(`SIF_ADDR_CTRL, 8'h0c);
        wr(`SIF_ADDR_FLAG, 8'h07);
        far.frame(8'h01, 1'b0, 1'b1);
        rd(`SIF_ADDR_CTRL, 8'h70, 8'h60);
        rd(`SIF_ADDR_FLAG, 8'h07, 8'h06);
        wr(`SIF_ADDR_CTRL, 8'h64);
        rd(`SIF_ADDR_CTRL, 8'h70, 8'h00);
        wr(`SIF_ADDR_FLAG, 8'h06);
        far.frame(8'h03, 1'b1, 1'b0);
        wr(`SIF_ADDR_CTRL, 8'h04);
        rd(`SIF_ADDR_CTRL, 8'h70, 8'h10);
        rd(`SIF_ADDR_FLAG, 8'h07, 8'h04);
        wr(`SIF_ADDR_CTRL, 8'h00);
        chk(receive_enable_bit, 1'b0);
        rd(`SIF_ADDR_CTRL, 8'h70, 8'h00);
        chk(rx_trig_n, 2);
    endtask
    task automatic t_irq;
        wr(`SIF_ADDR_FLAG, 8'h07);
        wr(`SIF_ADDR_ENAB, 8'h01);
        far.tx_end();
        mask <= 2'b01;
        for (int p = 0; p < 4; p++) begin
            wr(`SIF_ADDR_PRIO, {2'b00, p[1:0], 4'h0});
            repeat (3) @(posedge clk);
            chk(lvl, p[1:0]);
            chk(req, p > 1);
        end
        wr(`SIF_ADDR_FLAG, 8'h01);
        repeat (3) @(posedge clk);
        chk(req, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_irq();
        summarize();
    end
endmodule
`default_nettype wire
